// *** hdl/irq_ctrl.sv ***
// Interrupt controller: pin edge detection, request flags, enables,
// priority selection and the exception entry sequence.
// Assumes pins and peripheral events are synchronous to mclk and that the
// core applies set_mask to its global mask bit.
`timescale 1ns/1ps

module irq_ctrl (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire irq_ctrl_pkg::reg_req_t    reg_req,
  output logic [7:0]                     reg_rdata,
  input  wire logic [3:0]                edge_request_pins,    // R08
  input  wire logic [7:0]                grouped_request_pins, // R08
  input  wire irq_ctrl_pkg::periph_evt_t periph_evt,
  input  wire logic                      mask_bit,
  input  wire logic                      instr_end,
  output irq_ctrl_pkg::exc_out_t         exc_out,
  output logic                           irq_pending
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [3:0]              edge_pin_polarity;
    logic [7:0]              grouped_pin_polarity;
    logic [3:0]              edge_pin_enables;
    logic [1:0]              timer_enables;
    logic                    direct_enable;
    logic                    converter_enable;
    logic                    serial1_enable;
    logic [7:0]              grouped_pin_enables;
    logic [3:0]              pin_function;
    logic [3:0]              edge_flags;
    logic                    timer_b1_flag;
    logic                    timer_a_flag;
    logic                    direct_flag;
    logic                    converter_done_flag;
    logic                    serial1_done_flag;
    logic [7:0]              grouped_pin_flags;
    logic [3:0]              edge_prev;
    logic [7:0]              grouped_prev;
    logic                    start_prev;
    logic [7:0]              rdata;
    irq_ctrl_pkg::exc_state_t exc_state;
    logic [3:0]              count;
    irq_ctrl_pkg::exc_out_t  exc;
    logic                    pending;
  } state_t;

  state_t s;
  state_t next_s;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Polarity one selects the rising edge, zero the falling edge
  function automatic logic [7:0] edge_hits(input logic [7:0] prev,
                                           input logic [7:0] cur,
                                           input logic [7:0] pol);
    edge_hits = (prev ^ cur) & ~(cur ^ pol);
  endfunction

  // Lowest vector number is the highest priority
  function automatic logic [5:0] pick_first(input logic [23:0] req);
    logic [5:0] res;
    res = 6'h00;
    for (int i = irq_ctrl_pkg::NUM_VECTORS - 1; i >= 0; i--) begin
      if (req[i]) begin
        res = {1'b1, 5'(i)};
      end
    end
    pick_first = res;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  logic [7:0]  edge_hit;
  logic [7:0]  grp_hit;
  logic        conv_done;
  logic [23:0] presented;
  logic [5:0]  winner;
  logic [7:0]  w;
  logic        wr_req1;
  logic        wr_req2;
  logic        wr_req3;

  always_comb begin
    next_s = s;
    w = reg_req.wdata;
    edge_hit = edge_hits({4'h0, s.edge_prev}, {4'h0, edge_request_pins},
                         {4'h0, s.edge_pin_polarity}); // R09
    grp_hit = edge_hits(s.grouped_prev, grouped_request_pins,
                        s.grouped_pin_polarity); // R12 R16
    conv_done = s.start_prev & ~periph_evt.converter_start_flag; // R01
    wr_req1 = reg_req.wr && (reg_req.addr == irq_ctrl_pkg::ADDR_REQUEST_ONE);
    wr_req2 = reg_req.wr && (reg_req.addr == irq_ctrl_pkg::ADDR_REQUEST_TWO);
    wr_req3 = reg_req.wr && (reg_req.addr == irq_ctrl_pkg::ADDR_REQUEST_THREE);

    next_s.edge_prev    = edge_request_pins;
    next_s.grouped_prev = grouped_request_pins;
    next_s.start_prev   = periph_evt.converter_start_flag;

    // Flags: a write of zero clears, a set in the same cycle wins
    if (wr_req1) begin
      next_s.edge_flags    = s.edge_flags & w[3:0]; // R04
      next_s.timer_b1_flag = s.timer_b1_flag & w[irq_ctrl_pkg::BIT_TIMER_B1];
      next_s.timer_a_flag  = s.timer_a_flag & w[irq_ctrl_pkg::BIT_TIMER_A];
    end
    if (wr_req2) begin
      next_s.direct_flag         = s.direct_flag & w[irq_ctrl_pkg::BIT_DIRECT]; // R04
      next_s.converter_done_flag = s.converter_done_flag & w[irq_ctrl_pkg::BIT_CONVERTER];
      next_s.serial1_done_flag   = s.serial1_done_flag & w[irq_ctrl_pkg::BIT_SERIAL1];
    end
    if (wr_req3) begin
      next_s.grouped_pin_flags = s.grouped_pin_flags & w; // R04
    end
    next_s.edge_flags = next_s.edge_flags | (edge_hit[3:0] & s.pin_function); // R10 R21
    next_s.grouped_pin_flags = next_s.grouped_pin_flags | grp_hit; // R07 R21
    next_s.timer_b1_flag = next_s.timer_b1_flag | periph_evt.timer_b1_ovf; // R17
    next_s.timer_a_flag  = next_s.timer_a_flag | periph_evt.timer_a_ovf;
    next_s.direct_flag   = next_s.direct_flag | periph_evt.direct_done;
    next_s.converter_done_flag = next_s.converter_done_flag | conv_done; // R01
    next_s.serial1_done_flag   = next_s.serial1_done_flag | periph_evt.serial1_done; // R02

    // Control register writes
    if (reg_req.wr) begin
      if (reg_req.addr == irq_ctrl_pkg::ADDR_EDGE_SEL_ONE) begin
        next_s.edge_pin_polarity = w[3:0];
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_EDGE_SEL_TWO) begin
        next_s.grouped_pin_polarity = w;
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_ENABLE_ONE) begin
        next_s.edge_pin_enables = w[3:0];
        next_s.timer_enables    = {w[irq_ctrl_pkg::BIT_TIMER_B1], w[irq_ctrl_pkg::BIT_TIMER_A]};
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_ENABLE_TWO) begin
        next_s.direct_enable    = w[irq_ctrl_pkg::BIT_DIRECT];
        next_s.converter_enable = w[irq_ctrl_pkg::BIT_CONVERTER];
        next_s.serial1_enable   = w[irq_ctrl_pkg::BIT_SERIAL1];
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_ENABLE_THREE) begin
        next_s.grouped_pin_enables = w;
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_PORT_MODE_ONE) begin
        next_s.pin_function = w[3:0];
      end
    end

    // Read data stands one cycle only
    next_s.rdata = irq_ctrl_pkg::RESET_BYTE;
    if (reg_req.rd) begin
      if (reg_req.addr == irq_ctrl_pkg::ADDR_EDGE_SEL_ONE) begin
        next_s.rdata = {4'h0, s.edge_pin_polarity};
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_EDGE_SEL_TWO) begin
        next_s.rdata = s.grouped_pin_polarity;
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_ENABLE_ONE) begin
        next_s.rdata = {s.timer_enables, 2'b00, s.edge_pin_enables};
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_ENABLE_TWO) begin
        next_s.rdata = {s.direct_enable, s.converter_enable, 1'b0, s.serial1_enable, 4'h0};
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_ENABLE_THREE) begin
        next_s.rdata = s.grouped_pin_enables;
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_REQUEST_ONE) begin
        next_s.rdata = {s.timer_b1_flag, s.timer_a_flag, 2'b00, s.edge_flags}
                       | irq_ctrl_pkg::REQ_ONE_FIXED_ONES;
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_REQUEST_TWO) begin
        next_s.rdata = {s.direct_flag, s.converter_done_flag, 1'b0,
                        s.serial1_done_flag, 4'h0}; // R03
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_REQUEST_THREE) begin
        next_s.rdata = s.grouped_pin_flags;
      end else if (reg_req.addr == irq_ctrl_pkg::ADDR_PORT_MODE_ONE) begin
        next_s.rdata = {4'h0, s.pin_function};
      end
    end

    // Presented requests, indexed by vector number
    presented = 24'h000000;
    for (int i = 0; i < 4; i++) begin
      presented[int'(irq_ctrl_pkg::VEC_EDGE_PIN0) + i] =
        s.edge_flags[i] & s.edge_pin_enables[i]; // R11 R14 R23
    end
    presented[irq_ctrl_pkg::VEC_GROUPED] =
      |(s.grouped_pin_flags & s.grouped_pin_enables); // R13 R15 R23
    presented[irq_ctrl_pkg::VEC_DIRECT]    = s.direct_flag & s.direct_enable; // R17
    presented[irq_ctrl_pkg::VEC_TIMER_A]   = s.timer_a_flag & s.timer_enables[0];
    presented[irq_ctrl_pkg::VEC_TIMER_B1]  = s.timer_b1_flag & s.timer_enables[1];
    presented[irq_ctrl_pkg::VEC_SERIAL1]   = s.serial1_done_flag & s.serial1_enable;
    presented[irq_ctrl_pkg::VEC_CONVERTER] = s.converter_done_flag & s.converter_enable;
    winner = pick_first(presented); // R18
    next_s.pending = winner[5];

    // Exception entry; flags are never touched here
    next_s.exc.set_mask      = 1'b0;
    next_s.exc.handler_start = 1'b0;
    case (s.exc_state)
      irq_ctrl_pkg::EXC_IDLE: begin
        if (instr_end && winner[5] && !mask_bit) begin // R19 R20 R05
          next_s.exc_state        = irq_ctrl_pkg::EXC_SAVE;
          next_s.count            = irq_ctrl_pkg::SAVE_STATES - 4'h1; // R22
          next_s.exc.vector       = winner[4:0];
          next_s.exc.busy         = 1'b1;
          next_s.exc.push_context = 1'b1;
        end
      end
      irq_ctrl_pkg::EXC_SAVE: begin
        if (s.count == 4'h0) begin
          next_s.exc_state        = irq_ctrl_pkg::EXC_VFETCH;
          next_s.count            = irq_ctrl_pkg::VFETCH_STATES - 4'h1; // R22
          next_s.exc.push_context = 1'b0;
          next_s.exc.vector_fetch = 1'b1;
          next_s.exc.set_mask     = 1'b1; // R20
        end else begin
          next_s.count = s.count - 4'h1;
        end
      end
      irq_ctrl_pkg::EXC_VFETCH: begin
        if (s.count == 4'h0) begin
          next_s.exc_state        = irq_ctrl_pkg::EXC_IFETCH;
          next_s.count            = irq_ctrl_pkg::IFETCH_STATES - 4'h1; // R22
          next_s.exc.vector_fetch = 1'b0;
        end else begin
          next_s.count = s.count - 4'h1;
        end
      end
      irq_ctrl_pkg::EXC_IFETCH: begin
        if (s.count == 4'h0) begin
          next_s.exc_state = irq_ctrl_pkg::EXC_INTERNAL;
          next_s.count     = irq_ctrl_pkg::INTERNAL_STATES - 4'h1; // R22
        end else begin
          next_s.count = s.count - 4'h1;
        end
      end
      irq_ctrl_pkg::EXC_INTERNAL: begin
        if (s.count == 4'h0) begin
          next_s.exc_state         = irq_ctrl_pkg::EXC_IDLE;
          next_s.exc.busy          = 1'b0;
          next_s.exc.handler_start = 1'b1;
        end else begin
          next_s.count = s.count - 4'h1;
        end
      end
      default: begin
        next_s.exc_state = irq_ctrl_pkg::EXC_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0; // R06
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata   = s.rdata;
  assign exc_out     = s.exc;
  assign irq_pending = s.pending;

endmodule

// *** hdl/irq_ctrl_pkg.sv ***
// Constants, register map and state types of the interrupt controller.
// Assumes one clock domain and a CPU core that reports instruction ends.
//
// Summary of operation
// R01: Converter done flag sets when start flag falls
// R02: Serial unit one completion sets its done flag
// R03: Unused request register two bits read zero
// R04: Writing zero clears a flag; one does nothing
// R05: Acceptance leaves the request flag set
// R06: Reset clears all grouped pin flags
// R07: Selected edge on grouped pin n sets flag n
// R08: Four edge pins plus eight grouped pins
// R09: Edge pin polarity picks rising or falling edge
// R10: Edge flag needs pin assigned to request function
// R11: Edge pin enable zero suppresses its request
// R12: Grouped pin polarity picks rising or falling edge
// R13: Grouped pin enable zero suppresses its request
// R14: Edge pins 3..0 use vectors 7..4, pin 0 first
// R15: All grouped pins share vector eight
// R16: Grouped flags set even in port usage
// R17: Internal sources flagged, enabled, vectored 19 to 9
// R18: Highest priority enabled request wins, rest pending
// R19: Global mask bit set holds every request pending
// R20: Accept at instruction end, push, mask, vector, jump
// R21: Clear colliding with request still takes exception
// R22: Save 4, vector 2, fetch 4, internal 4 states
// R23: Presented request is flag AND enable
package irq_ctrl_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_EDGE_SEL_ONE = 4'h0;
  localparam logic [3:0] ADDR_EDGE_SEL_TWO = 4'h1;
  localparam logic [3:0] ADDR_ENABLE_ONE   = 4'h2;
  localparam logic [3:0] ADDR_ENABLE_TWO   = 4'h3;
  localparam logic [3:0] ADDR_ENABLE_THREE = 4'h4;
  localparam logic [3:0] ADDR_REQUEST_ONE  = 4'h5;
  localparam logic [3:0] ADDR_REQUEST_TWO  = 4'h6;
  localparam logic [3:0] ADDR_REQUEST_THREE = 4'h7;
  localparam logic [3:0] ADDR_PORT_MODE_ONE = 4'h8;

  // Field positions
  localparam int BIT_TIMER_B1  = 7;
  localparam int BIT_TIMER_A   = 6;
  localparam int BIT_DIRECT    = 7;
  localparam int BIT_CONVERTER = 6;
  localparam int BIT_SERIAL1   = 4;
  localparam logic [7:0] REQ_ONE_FIXED_ONES = 8'h10;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Vector numbers
  localparam logic [4:0] VEC_EDGE_PIN0  = 5'h04;
  localparam logic [4:0] VEC_GROUPED    = 5'h08;
  localparam logic [4:0] VEC_DIRECT     = 5'h09;
  localparam logic [4:0] VEC_TIMER_A    = 5'h0b;
  localparam logic [4:0] VEC_TIMER_B1   = 5'h0c;
  localparam logic [4:0] VEC_SERIAL1    = 5'h10;
  localparam logic [4:0] VEC_CONVERTER  = 5'h13;
  localparam int         NUM_VECTORS    = 24;

  // Exception sequence lengths in clock states
  localparam logic [3:0] SAVE_STATES     = 4'h4;
  localparam logic [3:0] VFETCH_STATES   = 4'h2;
  localparam logic [3:0] IFETCH_STATES   = 4'h4;
  localparam logic [3:0] INTERNAL_STATES = 4'h4;

  typedef enum logic [2:0] {
    EXC_IDLE,
    EXC_SAVE,
    EXC_VFETCH,
    EXC_IFETCH,
    EXC_INTERNAL
  } exc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       timer_b1_ovf;
    logic       timer_a_ovf;
    logic       direct_done;
    logic       converter_start_flag;
    logic       serial1_done;
  } periph_evt_t;

  typedef struct packed {
    logic       busy;
    logic       push_context;
    logic       vector_fetch;
    logic       set_mask;
    logic       handler_start;
    logic [4:0] vector;
  } exc_out_t;

endpackage

// *** tb/irq_ctrl_monitor.sv ***
// Concurrent checks on the interrupt controller ports.
// Assumes a single mclk domain; bound to irq_ctrl at the foot of this file.
`timescale 1ns/1ps

module irq_ctrl_monitor (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire irq_ctrl_pkg::reg_req_t reg_req,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   mask_bit,
  input wire logic                   instr_end,
  input wire irq_ctrl_pkg::exc_out_t exc_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ============================================================
  // Register port
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer cycle");
  a_unmapped_zero: assert property (reg_req.rd && reg_req.addr > 4'h8 |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");

  // ============================================================
  // Acceptance and entry sequence
  a_accept_cause: assert property ($rose(exc_out.busy) |-> $past(instr_end) && !$past(mask_bit))
    else $error("entry started without instruction end or while masked");
  a_mask_holds: assert property (instr_end && mask_bit && !exc_out.busy |=> !exc_out.busy)
    else $error("request accepted while masked");
  a_accept_end: assert property (!instr_end && !exc_out.busy |=> !exc_out.busy)
    else $error("entry started inside an instruction");
  a_push_len: assert property ($rose(exc_out.push_context) |->
    exc_out.push_context [*4] ##1 !exc_out.push_context)
    else $error("context push not four states");
  a_vfetch_seq: assert property ($fell(exc_out.push_context) |->
    (exc_out.vector_fetch && exc_out.set_mask) ##1
    (exc_out.vector_fetch && !exc_out.set_mask) ##1 !exc_out.vector_fetch)
    else $error("vector fetch or mask set out of order");
  a_handler_time: assert property ($rose(exc_out.busy) |->
    ##13 exc_out.busy ##1 (!exc_out.busy && exc_out.handler_start))
    else $error("handler start not fourteen states after acceptance");
  a_vector_hold: assert property (exc_out.busy && $past(exc_out.busy) |-> $stable(exc_out.vector))
    else $error("vector changed during entry");
  a_vector_legal: assert property ($rose(exc_out.busy) |->
    exc_out.vector inside {5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0b, 5'h0c, 5'h10, 5'h13})
    else $error("vector outside the assigned numbers");
endmodule

bind irq_ctrl irq_ctrl_monitor mon (
  .mclk      (mclk),
  .rst       (rst),
  .reg_req   (reg_req),
  .reg_rdata (reg_rdata),
  .mask_bit  (mask_bit),
  .instr_end (instr_end),
  .exc_out   (exc_out)
);

// *** tb/core_model.sv ***
// Behavioural CPU core facing the controller's exception port.
// Assumes the bench pulses clr_mask to model a return with the mask open.
`timescale 1ns/1ps

module core_model (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   clr_mask,
  input wire irq_ctrl_pkg::exc_out_t exc_out,
  output logic                       instr_end,
  output logic                       mask_bit,
  output logic [4:0]                 last_vec,
  output logic [7:0]                 taken
);
  logic [1:0] cnt;

  // ============================================================
  // Four-state instructions; none end while the entry runs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt       <= 2'h0;
      instr_end <= 1'b0;
      mask_bit  <= 1'b1;
      last_vec  <= 5'h00;
      taken     <= 8'h00;
    end else begin
      cnt       <= cnt + 2'h1;
      instr_end <= (cnt == 2'h3) && !exc_out.busy;
      if (exc_out.set_mask) begin
        mask_bit <= 1'b1;
      end else if (clr_mask) begin
        mask_bit <= 1'b0;
      end
      if (exc_out.handler_start) begin
        taken    <= taken + 8'h01;
        last_vec <= exc_out.vector;
      end
    end
  end
endmodule

// *** tb/external_internal_irq_controller_tb_top.sv ***
// Register-level tests of the interrupt controller with a core model.
// Assumes all stimulus synchronous to mclk, driven at its rising edge.
`timescale 1ns/1ps

module external_internal_irq_controller_tb_top;
  logic mclk, rst, clr, ie, mb, pend;
  irq_ctrl_pkg::reg_req_t      req;
  irq_ctrl_pkg::periph_evt_t   ev;
  irq_ctrl_pkg::exc_out_t      xo;
  logic [7:0] rdata, gp, taken;
  logic [3:0] ep;
  logic [4:0] lv;
  int failures, checks;

  irq_ctrl dut (.mclk(mclk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .edge_request_pins(ep),
    .grouped_request_pins(gp), .periph_evt(ev), .mask_bit(mb), .instr_end(ie), .exc_out(xo),
    .irq_pending(pend));
  core_model core (.mclk(mclk), .rst(rst), .clr_mask(clr), .exc_out(xo), .instr_end(ie),
    .mask_bit(mb), .last_vec(lv), .taken(taken));

  // ============================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic pins(input logic [3:0] e, input logic [7:0] g);
    @(posedge mclk);
    ep <= e;
    gp <= g;
    repeat (3) @(posedge mclk);
  endtask
  task automatic evt(input logic [4:0] v);
    @(posedge mclk);
    ev <= v;
  endtask
  // Opens the mask once; the model closes it again on set_mask
  task automatic take(input logic [7:0] exp);
    logic [7:0] n;
    n = taken;
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    for (int i = 0; i < 60 && taken == n; i++) @(posedge mclk);
    #1 chk(taken - n, 8'h01);
    chk({3'h0, lv}, exp);
  endtask
  task automatic note(input string s);
    $display("%0s test done", s);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ============================================================
  // Clock, reset, watchdog
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    finish_test();
  end

  // ============================================================
  // Tests
  initial begin
    rst = 1'b1;
    clr = 1'b0;
    req = '0;
    ev = '0;
    ep = 4'h0;
    gp = 8'h00;
    failures = 0;
    checks = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) rd(4'(i), (i == 5) ? 8'h10 : 8'h00);
    note("reset");
    wr(3, 8'hff);
    rd(3, 8'hd0);
    evt(5'b00010);
    evt(5'b11101);
    evt(5'b00000);
    rd(6, 8'hd0);
    rd(5, 8'hd0);
    wr(6, 8'hbf);
    rd(6, 8'h90);
    wr(6, 8'hff);
    rd(6, 8'h90);
    wr(6, 8'h00);
    wr(5, 8'h00);
    rd(5, 8'h10);
    note("peripheral");
    wr(1, 8'h0f);
    pins(4'h0, 8'hff);
    rd(7, 8'h0f);
    pins(4'h0, 8'h00);
    rd(7, 8'hff);
    wr(7, 8'h00);
    rd(7, 8'h00);
    note("grouped");
    // Pins held high while the function is switched, so no false flag
    pins(4'hf, 8'h00);
    rd(5, 8'h10);
    wr(8, 8'h0f);
    wr(0, 8'h05);
    pins(4'h0, 8'h00);
    rd(5, 8'h1a);
    pins(4'hf, 8'h00);
    rd(5, 8'h1f);
    note("edge");
    repeat (8) @(posedge mclk);
    #1 chk({7'h0, pend}, 8'h00);
    wr(2, 8'h0f);
    repeat (3) @(posedge mclk);
    #1 chk({7'h0, pend}, 8'h01);
    take(8'h04);
    rd(5, 8'h1f);
    wr(5, 8'h1e);
    take(8'h05);
    wr(5, 8'h00);
    wr(4, 8'h01);
    pins(4'hf, 8'h01);
    take(8'h08);
    wr(7, 8'h00);
    evt(5'b00001);
    evt(5'b00000);
    take(8'h10);
    // Clear and a new serial event meet in one cycle; the set must win
    fork
      wr(6, 8'h00);
      begin
        evt(5'b00001);
        evt(5'b00000);
      end
    join
    rd(6, 8'h10);
    evt(5'b00001);
    evt(5'b00000);
    repeat (30) @(posedge mclk);
    chk(taken, 8'h04);
    note("exception");
    finish_test();
  end
endmodule
